// [core/gpl_pkg.sv]
package gpl_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_SERIAL_POLL_RESPONSE_REG  = 8'h00;
	localparam logic [7:0] OFS_AUXILIARY_COMMAND_REG = 8'h04;
	localparam logic [7:0] OFS_ACCESSORY_REG_B = 8'h08;
	localparam logic [7:0] OFS_ACCESSORY_REG_I = 8'h0c;
	localparam logic [7:0] OFS_ACCRE = 8'h10;
	localparam logic [7:0] OFS_IMR0  = 8'h14;
	localparam logic [7:0] OFS_ISR0  = 8'h18;
	localparam logic [7:0] OFS_INTERRUPT_MASK_ONE  = 8'h1c;
	localparam logic [7:0] OFS_INTERRUPT_STATUS_ONE  = 8'h20;
	localparam logic [7:0] OFS_IMR2  = 8'h24;
	localparam logic [7:0] OFS_ISR2  = 8'h28;
	localparam logic [7:0] OFS_ADDRESS_STATUS_REG  = 8'h2c;
	localparam logic [7:0] OFS_PPR   = 8'h30;
	// ==========================================================
	// field positions
	localparam int B_RSV    = 6;
	localparam int B_ISS    = 4;
	localparam int B_INV    = 3;
	localparam int B_SPEND  = 1;
	localparam int B_PP1    = 2;
	localparam int B_TRIGHO = 3;
	localparam int B_CLRHO  = 2;
	localparam int B_RLC    = 1;
	localparam int B_SUMMARY_INTERRUPT_ONE   = 7;
	localparam int B_SUMMARY_INTERRUPT_ZERO   = 6;
	localparam int B_TRIG   = 7;
	localparam int B_UNC    = 5;
	localparam int B_DCAS   = 3;
	localparam int B_GLOBAL_INTERRUPT_ENABLE  = 7;
	localparam int B_STATUS_BYTE_OUT_FLAG   = 6;
	localparam int B_LOCKOUT_CHANGE_FLAG   = 5;
	localparam int B_ATNI   = 4;
	localparam int B_CICC   = 3;
	localparam logic [7:0] IMR2_RST = 8'h80;
	// ==========================================================
	// auxiliary command codes, low five bits of a write
	localparam logic [4:0] AUX_VALID = 5'h03;
	localparam logic [4:0] AUX_RTL   = 5'h02;
	localparam logic [4:0] AUX_LEGACY_SERVICE_REQUEST_FLAG  = 5'h04;
	localparam logic [4:0] AUX_NRSV2 = 5'h05;
	localparam logic [4:0] AUX_REQT  = 5'h06;
	localparam logic [4:0] AUX_REQF  = 5'h07;
	localparam logic [4:0] AUX_IST   = 5'h08;
	localparam logic [4:0] AUX_NIST  = 5'h09;
	localparam logic [4:0] AUX_DAI   = 5'h0a;
	localparam logic [4:0] AUX_NDAI  = 5'h0b;
	localparam logic [4:0] AUX_SIC   = 5'h0c;
	localparam logic [4:0] AUX_NSIC  = 5'h0d;
	localparam logic [4:0] AUX_SRE   = 5'h0e;
	localparam logic [4:0] AUX_NSRE  = 5'h0f;
	// ==========================================================
	// bus command bytes (ATN true)
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_PPC = 7'h05;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_PPU = 7'h15;
	localparam logic [2:0] PPE_HI  = 3'h6;
	localparam logic [2:0] PPD_HI  = 3'h7;
	// 100 us system controller minimums, for software timing
	localparam int T_IFC_MIN_US = 100;
	localparam int T_REN_MIN_US = 100;
	localparam int CLK_MHZ      = 100;
	localparam int IFC_MIN_CYC  = T_IFC_MIN_US * CLK_MHZ;
	typedef enum logic [1:0] {SR_NPRS, SR_SRQS, SR_APRS} gpl_sr_e;
	// link-side status from the talker/listener functions
	typedef struct packed {
		logic       atn;
		logic       listener;
		logic       ren;
		logic       cmd_valid;
		logic [6:0] cmd_byte;
		logic       mla;
		logic       sb_req;
		logic       sb_done;
	} gpl_link_s;
endpackage

// [core/gpl_poll_event.sv]
`timescale 1ns/1ps
module gpl_poll_event
	import gpl_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire gpl_link_s   i_link,
	output logic             o_srq,
	output logic      [7:0]  o_sb_data,
	output logic             o_sb_valid,
	output logic             o_sb_eoi,
	output logic      [7:0]  o_pp_resp,
	output logic             o_ist,
	output logic             o_dac_holdoff,
	output logic             o_int_n_o,
	output logic             o_int_n_oe,
	output logic             o_ifc,
	output logic             o_ren,
	output logic             o_atn,
	output logic             o_cic
);
	// ==========================================================
	// flag update: hardware set wins over software clear
	function automatic logic [7:0] upd(input logic [7:0] f,
		input logic [7:0] clr, input logic [7:0] set);
		upd = (f & ~clr) | set;
	endfunction

	// ==========================================================
	// bus decode
	logic        ack_r;
	wire         req     = i_wb_cyc & i_wb_stb & ~ack_r;
	wire         wr      = req & i_wb_we & i_wb_sel[0];
	wire  [7:0]  wd      = i_wb_dat[7:0];
	wire         wr_serial_poll_response_reg = wr & (i_wb_adr == OFS_SERIAL_POLL_RESPONSE_REG);
	wire         wr_aux  = wr & (i_wb_adr == OFS_AUXILIARY_COMMAND_REG);
	wire         wr_isr0 = wr & (i_wb_adr == OFS_ISR0);
	wire         wr_interrupt_status_one = wr & (i_wb_adr == OFS_INTERRUPT_STATUS_ONE);
	wire         wr_isr2 = wr & (i_wb_adr == OFS_ISR2);
	wire  [4:0]  aux     = wr_aux ? wd[4:0] : 5'h1f;

	logic [7:0] serial_poll_response_reg_r;
	logic [7:0] accessory_reg_b_r;
	logic [7:0] accessory_reg_i_r;
	logic [7:0] accre_r;
	logic [7:0] ppr_r;
	logic [7:0] imr0_r;
	logic [7:0] interrupt_mask_one_r;
	logic [7:0] imr2_r;
	logic [7:0] isr0_r;
	logic [7:0] interrupt_status_one_r;
	logic [7:0] isr2_r;
	logic       legacy_r;
	logic       rsv_arm_r;
	logic       rsv_r;
	logic       ist_r;
	logic       dai_r;
	logic       rem_r;
	logic       llo_r;
	logic       poll_pending_flag_r;
	logic       wait_host_r;
	logic       rqs_sent_r;
	logic       pp_en_r;
	logic       pp_sense_r;
	logic       pp_cfg_r;
	logic       atn_d_r;
	logic [2:0] pp_line_r;
	gpl_sr_e    sr_r;

	// ==========================================================
	// service request
	wire        rsv    = rsv_r | legacy_r | serial_poll_response_reg_r[B_RSV];
	wire        spas   = i_link.sb_req | o_sb_valid | wait_host_r;
	wire        ist    = accessory_reg_b_r[B_ISS] ? (sr_r == SR_SRQS) : ist_r;
	wire        atn_rise = i_link.atn & ~atn_d_r;
	wire        sb_load = (i_link.sb_req & ~imr2_r[B_STATUS_BYTE_OUT_FLAG])
			| (wait_host_r & wr_serial_poll_response_reg);
	// rqs needs srq already up: a byte written late in
	// status-byte-out mode goes out with rqs low
	wire        rqs    = (sr_r == SR_SRQS) & ~rqs_sent_r;
	wire        sb_fin = i_link.sb_done & o_sb_valid;

	// ==========================================================
	// command byte decode
	wire [6:0]  cb     = i_link.cmd_byte;
	wire        cv     = i_link.cmd_valid;
	wire        is_get = cv & (cb == CMD_GET);
	wire        is_dcl = cv & (cb == CMD_DCL);
	wire        is_sdc = cv & (cb == CMD_SDC);
	wire        is_ppc = cv & (cb == CMD_PPC) & i_link.listener;
	wire        is_ppu = cv & (cb == CMD_PPU);
	wire        is_ppe = cv & pp_cfg_r & (cb[6:4] == PPE_HI);
	wire        is_ppd = cv & pp_cfg_r & (cb[6:4] == PPD_HI);
	wire        pp_any = is_ppc | is_ppu | is_ppe | is_ppd;
	wire        pp_auto = accessory_reg_i_r[B_PP1] & (ppr_r == 8'h00);
	wire        trig   = is_get & i_link.listener;
	wire        dcas   = is_dcl | (is_sdc & i_link.listener);
	wire        ho_trg = is_get & accre_r[B_TRIGHO];
	wire        ho_clr = (is_dcl | is_sdc) & accre_r[B_CLRHO];
	wire        unknown_command_flag    = (pp_any & ~accessory_reg_i_r[B_PP1]) | ho_trg | ho_clr;
	wire        holdoff = ho_trg | ho_clr | (dcas & interrupt_mask_one_r[B_DCAS]);

	// ==========================================================
	// remote/local
	wire        gtl    = cv & (cb == CMD_GTL) & i_link.listener;
	wire        rtl    = (aux == AUX_RTL) & ~llo_r;
	wire        rem_nxt = ~i_link.ren ? 1'b0
			: (i_link.mla & ~rem_r) ? 1'b1
			: ((gtl & ~llo_r) | rtl) ? 1'b0 : rem_r;
	wire        llo_nxt = i_link.ren & (llo_r | (cv & (cb == CMD_LLO)));
	wire        cic_nxt = (aux == AUX_SIC) | o_cic;

	// ==========================================================
	// flag sets and interrupt summary
	wire [7:0]  set0 = {6'h00, rem_nxt != rem_r, 1'b0};
	wire [7:0]  set1 = {trig, 1'b0, unknown_command_flag, 1'b0, dcas, 3'h0};
	wire [7:0]  set2 = {1'b0, i_link.sb_req & imr2_r[B_STATUS_BYTE_OUT_FLAG],
			llo_nxt != llo_r, atn_rise, cic_nxt != o_cic, 3'h0};
	wire        summary_interrupt_one = |(interrupt_status_one_r & interrupt_mask_one_r);
	wire        summary_interrupt_zero = |(isr0_r & imr0_r);
	wire        ev2  = |(isr2_r & imr2_r & 8'h78);
	wire        int_req = imr2_r[B_GLOBAL_INTERRUPT_ENABLE] & ~dai_r
			& (summary_interrupt_one | summary_interrupt_zero | ev2);

	// ==========================================================
	// parallel poll response byte
	wire [7:0]  pp_auto_b = (pp_en_r & (ist == pp_sense_r))
			? (8'h01 << pp_line_r) : 8'h00;
	wire [7:0]  pp_nxt = pp_auto ? pp_auto_b : ppr_r;

	// ==========================================================
	// read mux
	wire [7:0]  address_status_reg = {o_cic, o_ren, i_link.atn, o_ifc,
			llo_r, rem_r, o_srq, poll_pending_flag_r};
	logic [8:0] rd;
	always_comb begin
		rd = 9'h000;
		if (i_wb_adr == OFS_SERIAL_POLL_RESPONSE_REG)
			rd = {1'b0, serial_poll_response_reg_r};
		else if (i_wb_adr == OFS_ACCESSORY_REG_B)
			rd = {1'b0, accessory_reg_b_r};
		else if (i_wb_adr == OFS_ACCESSORY_REG_I)
			rd = {1'b0, accessory_reg_i_r};
		else if (i_wb_adr == OFS_ACCRE)
			rd = {1'b0, accre_r};
		else if (i_wb_adr == OFS_IMR0)
			rd = {1'b0, imr0_r};
		else if (i_wb_adr == OFS_ISR0)
			rd = {1'b0, summary_interrupt_one, summary_interrupt_zero, isr0_r[5:0]};
		else if (i_wb_adr == OFS_INTERRUPT_MASK_ONE)
			rd = {1'b0, interrupt_mask_one_r};
		else if (i_wb_adr == OFS_INTERRUPT_STATUS_ONE)
			rd = {1'b0, interrupt_status_one_r};
		else if (i_wb_adr == OFS_IMR2)
			rd = {1'b0, imr2_r};
		else if (i_wb_adr == OFS_ISR2)
			rd = {1'b0, isr2_r};
		else if (i_wb_adr == OFS_ADDRESS_STATUS_REG)
			rd = {ist, address_status_reg};
		else if (i_wb_adr == OFS_PPR)
			rd = {1'b0, ppr_r};
	end

	// ==========================================================
	// bus slave: one wait state, unmapped reads give zero
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ack_r    <= 1'b0;
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			ack_r    <= req;
			o_wb_ack <= req;
			o_wb_dat <= {23'h000000, rd};
		end
	end

	// ==========================================================
	// software-written configuration
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			accessory_reg_b_r <= 8'h00;
			accessory_reg_i_r <= 8'h00;
			accre_r <= 8'h00;
			ppr_r   <= 8'h00;
			imr0_r  <= 8'h00;
			interrupt_mask_one_r  <= 8'h00;
			imr2_r  <= IMR2_RST;
		end else if (wr) begin
			if (i_wb_adr == OFS_ACCESSORY_REG_B)
				accessory_reg_b_r <= wd;
			if (i_wb_adr == OFS_ACCESSORY_REG_I)
				accessory_reg_i_r <= wd;
			if (i_wb_adr == OFS_ACCRE)
				accre_r <= wd;
			if (i_wb_adr == OFS_PPR)
				ppr_r <= wd;
			if (i_wb_adr == OFS_IMR0)
				imr0_r <= wd;
			if (i_wb_adr == OFS_INTERRUPT_MASK_ONE)
				interrupt_mask_one_r <= wd;
			if (i_wb_adr == OFS_IMR2)
				imr2_r <= wd;
		end
	end

	// ==========================================================
	// sticky status, write one to clear
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			isr0_r <= 8'h00;
			interrupt_status_one_r <= 8'h00;
			isr2_r <= 8'h00;
		end else begin
			isr0_r <= upd(isr0_r, wr_isr0 ? wd : 8'h00, set0);
			interrupt_status_one_r <= upd(interrupt_status_one_r, wr_interrupt_status_one ? wd : 8'h00, set1);
			// status-byte-out also drops once the host supplies the byte
			isr2_r <= upd(isr2_r, (wr_isr2 ? wd : 8'h00)
				| (wr_serial_poll_response_reg ? 8'h40 : 8'h00), set2);
		end
	end

	// ==========================================================
	// service request state and aux flags
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			serial_poll_response_reg_r    <= 8'h00;
			legacy_r  <= 1'b0;
			rsv_arm_r <= 1'b0;
			rsv_r     <= 1'b0;
			ist_r     <= 1'b0;
			dai_r     <= 1'b0;
			sr_r      <= SR_NPRS;
		end else begin
			if (wr_serial_poll_response_reg)
				serial_poll_response_reg_r <= wd;
			// set-rsv machine: armed by reqt, fires on status write
			if (aux == AUX_REQT)
				rsv_arm_r <= 1'b1;
			else if ((aux == AUX_REQF) | (wr_serial_poll_response_reg & rsv_arm_r))
				rsv_arm_r <= 1'b0;
			if ((aux == AUX_REQF) | (sb_fin & rqs_sent_r))
				rsv_r <= 1'b0;
			else if (wr_serial_poll_response_reg & rsv_arm_r)
				rsv_r <= 1'b1;
			if (aux == AUX_LEGACY_SERVICE_REQUEST_FLAG)
				legacy_r <= 1'b1;
			else if ((aux == AUX_NRSV2) | sb_fin)
				legacy_r <= 1'b0;
			if (aux == AUX_IST)
				ist_r <= 1'b1;
			else if (aux == AUX_NIST)
				ist_r <= 1'b0;
			if (aux == AUX_DAI)
				dai_r <= 1'b1;
			else if (aux == AUX_NDAI)
				dai_r <= 1'b0;
			case (sr_r)
				SR_NPRS: if (rsv & ~spas) sr_r <= SR_SRQS;
				SR_SRQS: begin
					if (~rsv)
						sr_r <= SR_NPRS;
					else if (sb_fin)
						sr_r <= SR_APRS;
				end
				default: if (~rsv) sr_r <= SR_NPRS;
			endcase
		end
	end

	// ==========================================================
	// serial poll response
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_sb_data   <= 8'h00;
			o_sb_valid  <= 1'b0;
			o_sb_eoi    <= 1'b0;
			wait_host_r <= 1'b0;
			rqs_sent_r  <= 1'b0;
			poll_pending_flag_r      <= 1'b0;
			atn_d_r     <= 1'b0;
		end else begin
			atn_d_r <= i_link.atn;
			if (i_link.sb_req & imr2_r[B_STATUS_BYTE_OUT_FLAG])
				wait_host_r <= 1'b1;
			else if (wr_serial_poll_response_reg)
				wait_host_r <= 1'b0;
			if (sb_load) begin
				// bit 6 carries RQS, never the stored rsv
				o_sb_data  <= {wd[7] & wait_host_r | serial_poll_response_reg_r[7]
					& ~wait_host_r, rqs,
					wait_host_r ? wd[5:0] : serial_poll_response_reg_r[5:0]};
				o_sb_valid <= 1'b1;
				o_sb_eoi   <= accessory_reg_b_r[B_SPEND];
				rqs_sent_r <= rqs;
				if (rqs)
					poll_pending_flag_r <= 1'b1;
			end else if (sb_fin | i_link.atn) begin
				o_sb_valid <= 1'b0;
				o_sb_eoi   <= 1'b0;
				if (i_link.atn)
					rqs_sent_r <= 1'b0;
			end
			if (atn_rise & ~sb_load)
				poll_pending_flag_r <= 1'b0;
		end
	end

	// ==========================================================
	// events, remote/local, parallel poll config, system control
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rem_r         <= 1'b0;
			llo_r         <= 1'b0;
			pp_en_r       <= 1'b0;
			pp_sense_r    <= 1'b0;
			pp_line_r     <= 3'h0;
			pp_cfg_r      <= 1'b0;
			o_pp_resp     <= 8'h00;
			o_ist         <= 1'b0;
			o_srq         <= 1'b0;
			o_dac_holdoff <= 1'b0;
			o_int_n_o     <= 1'b0;
			o_int_n_oe    <= 1'b0;
			o_ifc         <= 1'b0;
			o_ren         <= 1'b0;
			o_atn         <= 1'b0;
			o_cic         <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			llo_r <= llo_nxt;
			// ppe/ppd only count straight after an addressed ppc
			if (cv)
				pp_cfg_r <= is_ppc;
			if (pp_auto) begin
				if (is_ppe) begin
					pp_en_r    <= 1'b1;
					pp_sense_r <= cb[3];
					pp_line_r  <= cb[2:0];
				end else if (is_ppd | is_ppu)
					pp_en_r <= 1'b0;
			end
			o_pp_resp <= pp_nxt;
			o_ist     <= ist;
			o_srq     <= (sr_r == SR_SRQS);
			// released by the valid command only
			if (holdoff)
				o_dac_holdoff <= 1'b1;
			else if (aux == AUX_VALID)
				o_dac_holdoff <= 1'b0;
			// open collector: only the enable ever moves
			o_int_n_oe <= accessory_reg_b_r[B_INV] ? ~int_req : int_req;
			// atn from sic stays up: no go-to-standby in this block
			if (aux == AUX_SIC) begin
				o_ifc <= 1'b1;
				o_atn <= 1'b1;
			end else if (aux == AUX_NSIC)
				o_ifc <= 1'b0;
			o_cic <= cic_nxt;
			if (aux == AUX_SRE)
				o_ren <= 1'b1;
			else if (aux == AUX_NSRE)
				o_ren <= 1'b0;
		end
	end
endmodule

// [sim/gpl_poll_event_props.sv]
`timescale 1ns/1ps
module gpl_poll_event_props
	import gpl_pkg::*;
(
	input wire logic      i_clk_sys,
	input wire logic      i_rst,
	input wire logic      i_wb_cyc,
	input wire logic      i_wb_stb,
	input wire logic      o_wb_ack,
	input wire gpl_link_s i_link,
	input wire logic      o_srq,
	input wire logic      o_sb_valid,
	input wire logic      o_sb_eoi,
	input wire logic      o_dac_holdoff,
	input wire logic      o_int_n_o,
	input wire logic      o_ifc,
	input wire logic      o_atn,
	input wire logic      o_cic
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// bus handshake
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack missing one cycle after request");
	// ==========================================================
	// poll and event behaviour
	a_pin_low_only: assert property (o_int_n_o == 1'b0)
		else $error("interrupt pin driven high");
	a_eoi_in_poll: assert property (o_sb_eoi |-> o_sb_valid)
		else $error("eoi outside status byte");
	a_done_ends_poll: assert property (i_link.sb_done |=> !o_sb_valid)
		else $error("status byte still offered after accept");
	a_atn_ends_poll: assert property (i_link.atn && o_sb_valid |=> !o_sb_valid)
		else $error("status byte still offered under atn");
	a_srq_drops: assert property (i_link.sb_done && o_srq |-> ##[1:3] !o_srq)
		else $error("srq kept after poll read");
	a_holdoff_cause: assert property ($rose(o_dac_holdoff) |-> $past(i_link.cmd_valid))
		else $error("holdoff without command byte");
	a_sic_takes: assert property ($rose(o_ifc) |-> o_cic && o_atn)
		else $error("ifc without cic and atn");
	c_poll_eoi: cover property (o_sb_valid && o_sb_eoi);
	c_holdoff: cover property ($rose(o_dac_holdoff));
	c_sysctl: cover property ($rose(o_ifc));
endmodule
bind gpl_poll_event gpl_poll_event_props u_gpl_poll_event_props (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_link(i_link),
	.o_srq(o_srq), .o_sb_valid(o_sb_valid), .o_sb_eoi(o_sb_eoi),
	.o_dac_holdoff(o_dac_holdoff), .o_int_n_o(o_int_n_o),
	.o_ifc(o_ifc), .o_atn(o_atn), .o_cic(o_cic));

// [sim/gpl_bus_ctrl.sv]
`timescale 1ns/1ps
module gpl_bus_ctrl
	import gpl_pkg::*;
(
	input  wire logic i_clk_sys,
	output gpl_link_s o_link
);
	initial o_link = '0;
	// ==========================================================
	// levels change only right after an edge
	task automatic level(input logic atn, input logic lsn, input logic ren);
		@(posedge i_clk_sys);
		o_link.atn      <= atn;
		o_link.listener <= lsn;
		o_link.ren      <= ren;
	endtask
	// idle byte lines show the inverse, so a stale value never passes
	task automatic cmd(input logic [6:0] b);
		@(posedge i_clk_sys);
		o_link.cmd_valid <= 1'b1;
		o_link.cmd_byte  <= b;
		@(posedge i_clk_sys);
		o_link.cmd_valid <= 1'b0;
		o_link.cmd_byte  <= ~b;
	endtask
	// 0 asks for the status byte, 1 accepts it, 2 sends my listen address
	task automatic strobe(input int k);
		@(posedge i_clk_sys);
		o_link.sb_req  <= (k == 0);
		o_link.sb_done <= (k == 1);
		o_link.mla     <= (k == 2);
		@(posedge i_clk_sys);
		o_link.sb_req  <= 1'b0;
		o_link.sb_done <= 1'b0;
		o_link.mla     <= 1'b0;
	endtask
endmodule

// [sim/gpl_poll_event_tb.sv]
`timescale 1ns/1ps
module gpl_poll_event_tb;
	import gpl_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] q0;
	logic [31:0] rdat;
	logic        ack, srq, sbv, eoi, ist, hold, ino, ioe, ifc, ren, atn, cic;
	logic [7:0]  sbd, parallel_poll_response_reg;
	gpl_link_s   link;
	int          fails = 0;
	int          cmp_count = 0;
	int          cyc_n = 0;
	always #5 clk = ~clk;
	gpl_poll_event u_gpl_poll_event (.i_clk_sys(clk), .i_rst(rst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_link(link), .o_srq(srq), .o_sb_data(sbd), .o_sb_valid(sbv),
		.o_sb_eoi(eoi), .o_pp_resp(parallel_poll_response_reg), .o_ist(ist), .o_dac_holdoff(hold),
		.o_int_n_o(ino), .o_int_n_oe(ioe), .o_ifc(ifc), .o_ren(ren),
		.o_atn(atn), .o_cic(cic));
	gpl_bus_ctrl u_gpl_bus_ctrl (.i_clk_sys(clk), .o_link(link));
	// ==========================================================
	// bus access and checks
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s;
		// upper lanes carry junk: only the low byte may land
		wdat <= {d, d, d, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'h1, q);
	endtask
	task automatic aux(input logic [4:0] c);
		wr(OFS_AUXILIARY_COMMAND_REG, {3'h0, c});
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, 4'h1, q);
		cmp(q & m, e);
	endtask
	// sample one step after the edge so that its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// tests should take a little over 10000 cycles
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 30000) begin
			fails++;
			finish_test();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		we   <= 1'b0;
		adr  <= 8'h00;
		sel  <= 4'h0;
		wdat <= 32'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(OFS_IMR2, 32'hff, 32'h80);
		rdc(8'hfc, 32'hffffffff, 32'h0);
		// lane 0 off: the write must be ignored
		wb(1'b1, OFS_IMR0, 8'hff, 4'he, q0);
		rdc(OFS_IMR0, 32'hffffffff, 32'h0);
		cmp({ino, ioe}, 32'h0);
		$display("test reset done");
		wr(OFS_INTERRUPT_MASK_ONE, 8'h80);
		u_gpl_bus_ctrl.cmd(CMD_GET);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h80, 32'h0);
		u_gpl_bus_ctrl.level(1'b0, 1'b1, 1'b0);
		u_gpl_bus_ctrl.cmd(CMD_GET);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h80, 32'h80);
		cmp(ioe, 32'h1);
		wr(OFS_ACCESSORY_REG_B, 8'h08);
		tick(2);
		cmp(ioe, 32'h0);
		wr(OFS_ACCESSORY_REG_B, 8'h00);
		aux(AUX_DAI);
		tick(2);
		cmp(ioe, 32'h0);
		aux(AUX_NDAI);
		tick(2);
		cmp(ioe, 32'h1);
		wr(OFS_INTERRUPT_STATUS_ONE, 8'hff);
		wr(OFS_INTERRUPT_MASK_ONE, 8'h00);
		tick(2);
		cmp(ioe, 32'h0);
		$display("test interrupt done");
		wr(OFS_ACCRE, 8'h08);
		u_gpl_bus_ctrl.level(1'b0, 1'b0, 1'b0);
		u_gpl_bus_ctrl.cmd(CMD_GET);
		tick(2);
		cmp(hold, 32'h1);
		aux(AUX_VALID);
		u_gpl_bus_ctrl.cmd(CMD_SDC);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h08, 32'h0);
		cmp(hold, 32'h0);
		u_gpl_bus_ctrl.cmd(CMD_DCL);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h08, 32'h08);
		cmp(hold, 32'h0);
		wr(OFS_INTERRUPT_STATUS_ONE, 8'hff);
		wr(OFS_INTERRUPT_MASK_ONE, 8'h08);
		u_gpl_bus_ctrl.cmd(CMD_DCL);
		tick(2);
		cmp(hold, 32'h1);
		aux(AUX_VALID);
		wr(OFS_INTERRUPT_MASK_ONE, 8'h00);
		wr(OFS_INTERRUPT_STATUS_ONE, 8'hff);
		wr(OFS_ACCRE, 8'h04);
		u_gpl_bus_ctrl.cmd(CMD_SDC);
		tick(2);
		cmp(hold, 32'h1);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h28, 32'h20);
		aux(AUX_VALID);
		wr(OFS_ACCRE, 8'h00);
		wr(OFS_INTERRUPT_STATUS_ONE, 8'hff);
		$display("test holdoff done");
		u_gpl_bus_ctrl.cmd(CMD_PPC);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h20, 32'h0);
		u_gpl_bus_ctrl.level(1'b0, 1'b1, 1'b0);
		u_gpl_bus_ctrl.cmd(CMD_PPC);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h20, 32'h20);
		wr(OFS_INTERRUPT_STATUS_ONE, 8'hff);
		wr(OFS_ACCESSORY_REG_I, 8'h04);
		wr(OFS_PPR, 8'h00);
		aux(AUX_IST);
		u_gpl_bus_ctrl.cmd(CMD_PPC);
		u_gpl_bus_ctrl.cmd({PPE_HI, 4'ha});
		tick(2);
		cmp(parallel_poll_response_reg, 32'h04);
		cmp(ist, 32'h1);
		rdc(OFS_INTERRUPT_STATUS_ONE, 32'h20, 32'h0);
		aux(AUX_NIST);
		tick(2);
		cmp(ist, 32'h0);
		cmp(parallel_poll_response_reg, 32'h0);
		aux(AUX_IST);
		u_gpl_bus_ctrl.cmd(CMD_PPC);
		u_gpl_bus_ctrl.cmd({PPD_HI, 4'h0});
		tick(2);
		cmp(parallel_poll_response_reg, 32'h0);
		wr(OFS_ACCESSORY_REG_I, 8'h00);
		wr(OFS_PPR, 8'h10);
		tick(2);
		cmp(parallel_poll_response_reg, 32'h10);
		wr(OFS_PPR, 8'h00);
		$display("test parallel poll done");
		wr(OFS_ACCESSORY_REG_B, 8'h12);
		wr(OFS_SERIAL_POLL_RESPONSE_REG, 8'h21);
		aux(AUX_LEGACY_SERVICE_REQUEST_FLAG);
		tick(2);
		cmp({srq, ist}, 32'h3);
		u_gpl_bus_ctrl.strobe(0);
		tick(1);
		cmp({eoi, sbd}, 32'h161);
		u_gpl_bus_ctrl.strobe(1);
		tick(2);
		cmp({sbv, srq, ist}, 32'h0);
		rdc(OFS_ADDRESS_STATUS_REG, 32'h01, 32'h01);
		u_gpl_bus_ctrl.level(1'b1, 1'b1, 1'b0);
		u_gpl_bus_ctrl.level(1'b0, 1'b1, 1'b0);
		u_gpl_bus_ctrl.strobe(0);
		tick(1);
		cmp(sbd, 32'h21);
		u_gpl_bus_ctrl.level(1'b1, 1'b1, 1'b0);
		tick(2);
		cmp(sbv, 32'h0);
		rdc(OFS_ADDRESS_STATUS_REG, 32'h01, 32'h0);
		u_gpl_bus_ctrl.level(1'b0, 1'b1, 1'b0);
		wr(OFS_SERIAL_POLL_RESPONSE_REG, 8'h40);
		tick(2);
		cmp(srq, 32'h1);
		wr(OFS_SERIAL_POLL_RESPONSE_REG, 8'h00);
		tick(2);
		cmp(srq, 32'h0);
		$display("test legacy poll done");
		wr(OFS_ACCESSORY_REG_B, 8'h00);
		wr(OFS_IMR2, 8'hc0);
		aux(AUX_REQT);
		u_gpl_bus_ctrl.strobe(0);
		tick(2);
		cmp({sbv, ioe}, 32'h1);
		rdc(OFS_ISR2, 32'h40, 32'h40);
		wr(OFS_SERIAL_POLL_RESPONSE_REG, 8'h05);
		tick(1);
		cmp({sbv, sbd & 8'hbf}, 32'h105);
		rdc(OFS_ISR2, 32'h40, 32'h0);
		u_gpl_bus_ctrl.strobe(1);
		aux(AUX_REQF);
		wr(OFS_IMR2, 8'h80);
		$display("test status byte out done");
		u_gpl_bus_ctrl.level(1'b0, 1'b0, 1'b1);
		u_gpl_bus_ctrl.strobe(2);
		rdc(OFS_ADDRESS_STATUS_REG, 32'h04, 32'h04);
		rdc(OFS_ISR0, 32'h02, 32'h02);
		wr(OFS_ISR0, 8'h02);
		aux(AUX_RTL);
		rdc(OFS_ADDRESS_STATUS_REG, 32'h04, 32'h0);
		rdc(OFS_ISR0, 32'h02, 32'h02);
		u_gpl_bus_ctrl.cmd(CMD_LLO);
		u_gpl_bus_ctrl.strobe(2);
		aux(AUX_RTL);
		rdc(OFS_ADDRESS_STATUS_REG, 32'h0c, 32'h0c);
		u_gpl_bus_ctrl.level(1'b0, 1'b0, 1'b0);
		$display("test remote local done");
		aux(AUX_SIC);
		tick(2);
		cmp({ifc, cic, atn}, 32'h7);
		repeat (IFC_MIN_CYC) @(posedge clk);
		aux(AUX_NSIC);
		tick(2);
		cmp(ifc, 32'h0);
		aux(AUX_SRE);
		tick(2);
		cmp(ren, 32'h1);
		aux(AUX_NSRE);
		tick(2);
		cmp(ren, 32'h0);
		$display("test system control done");
		finish_test();
	end
endmodule
